// [pkg/cdr_pkg.sv]
// Package for the clock delay and full-scale range configuration registers
`default_nettype none
package cdr_pkg;
   // ****************************************************
   // Register indices and byte addresses
   // ****************************************************
   localparam logic [3:0] IDX_RANGE = 4'hB;
   localparam logic [3:0] IDX_COARSE = 4'hC;
   localparam logic [3:0] IDX_FINE = 4'hD;
   localparam logic [3:0] IDX_STATUS = 4'hE;
   localparam logic [5:0] ADDR_RANGE = {IDX_RANGE, 2'b00};
   localparam logic [5:0] ADDR_COARSE = {IDX_COARSE, 2'b00};
   localparam logic [5:0] ADDR_FINE = {IDX_FINE, 2'b00};
   localparam logic [5:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
   // ****************************************************
   // Reset values
   // ****************************************************
   localparam logic [15:0] RST_RANGE = 16'h4000;
   localparam logic [15:0] RST_COARSE = 16'h0004;
   localparam logic [15:0] RST_FINE = 16'h0000;
   // ****************************************************
   // Field positions and limits
   // ****************************************************
   localparam int RANGE_LSB = 0;
   localparam int RANGE_W = 15;
   localparam int COARSE_LSB = 4;
   localparam int COARSE_W = 12;
   localparam int SELECT_BIT = 3;
   localparam int DUTY_BIT = 2;
   localparam int FINE_LSB = 10;
   localparam int FINE_W = 6;
   localparam logic [11:0] COARSE_MAX = 12'h97F;
   localparam logic [14:0] RANGE_MID = 15'h4000;
   localparam logic [15:0] RANGE_WMASK = 16'h7FFF;
   localparam logic [15:0] COARSE_WMASK = 16'hFFFC;
   localparam logic [15:0] FINE_WMASK = 16'hFC00;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ****************************************************
   // Types
   // ****************************************************
   typedef struct packed {
      logic [14:0] rangeCode;
      logic [11:0] coarseDelayCode;
      logic [5:0] fineDelayCode;
      logic delayAdjustSelect;
      logic dutyStabiliserOn;
   } cdr_analog_t;
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_RESP = 2'b01
   } cdr_rd_state_t;
endpackage
`default_nettype wire

// [rtl/cdr_regfile.sv]
// Three-word register storage with registered read data
`timescale 1ns/10ps
`default_nettype none
module cdr_regfile (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic wrEn,
   input wire logic [1:0] wrSel,
   input wire logic [15:0] wrData,
   input wire logic [15:0] wrMask,
   input wire logic [1:0] rdSel,
   output logic [15:0] rdData,
   output logic [15:0] rangeWord,
   output logic [15:0] coarseWord,
   output logic [15:0] fineWord
);
   import cdr_pkg::*;
   logic [15:0] mem_q [0:2];
   logic [15:0] merged;

   assign merged = wrData & wrMask;
   assign rangeWord = mem_q[0];
   assign coarseWord = mem_q[1];
   assign fineWord = mem_q[2];

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mem_q[0] <= RST_RANGE;
         mem_q[1] <= RST_COARSE;
         mem_q[2] <= RST_FINE;
      end else if (wrEn && wrSel != 2'd3) begin
         mem_q[wrSel] <= merged; // [R10]
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdData <= 16'h0000;
      end else begin
         rdData <= (rdSel == 2'd3) ? 16'h0000 : mem_q[rdSel]; // [R10]
      end
   end
endmodule // cdr_regfile
`default_nettype wire

// [rtl/cdr_config_regs.sv]
// AXI4-Lite slave holding the range and aperture delay configuration
//
// Notes on behaviour
// [R1] The 15-bit range code is straight binary, 0 is 600 mV, 32767 is 1000 mV, 16384 is 800 mV.
// [R2] Software writes zero to the reserved range top bit and coarse low two bits.
// [R3] The 12-bit coarse delay code in bits 15:4 scales from 0 to 825 ps at 2431.
// [R4] Coarse codes of 2432 and above saturate at the maximum delay.
// [R5] Coarse and fine delays apply only while the select bit 3 is one.
// [R6] The duty-cycle stabiliser stays on while coarse bit 2 is one, its default.
// [R7] The 6-bit fine delay in bits 15:10 adds 0 to 2.3 ps on top of the coarse delay.
// [R8] Software keeps the ten reserved fine register low bits at zero.
// [R9] In extended control mode the mid-range code equals the non-extended nominal setting.
// [R10] Codes stay unchanged until rewritten and reads return the last written value.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module cdr_config_regs (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic extendedControl,
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output cdr_pkg::cdr_analog_t analogCtrl_q
);
   import cdr_pkg::*;

   // ****************************************************
   // Address decode
   // ****************************************************
   function automatic logic [1:0] regSel(input logic [5:0] addr);
      case (addr)
         ADDR_RANGE: regSel = 2'd0;
         ADDR_COARSE: regSel = 2'd1;
         ADDR_FINE: regSel = 2'd2;
         default: regSel = 2'd3;
      endcase
   endfunction

   function automatic logic [15:0] selMask(input logic [1:0] sel);
      case (sel)
         2'd0: selMask = RANGE_WMASK;
         2'd1: selMask = COARSE_WMASK;
         2'd2: selMask = FINE_WMASK;
         default: selMask = 16'h0000;
      endcase
   endfunction

   // ****************************************************
   // Write channel
   // ****************************************************
   logic [5:0] awAddr_q;
   logic awHeld_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic wHeld_q;
   logic [15:0] oldWord;
   logic [15:0] strobedWord;
   logic [1:0] wrSel;
   logic wrFire;
   logic awTake;
   logic wTake;
   logic [15:0] rangeWord;
   logic [15:0] coarseWord;
   logic [15:0] fineWord;

   assign awTake = s_axi_awvalid && s_axi_awready;
   assign wTake = s_axi_wvalid && s_axi_wready;
   assign wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;
   assign wrSel = regSel(awAddr_q);
   assign oldWord = (wrSel == 2'd0) ? rangeWord : (wrSel == 2'd1) ? coarseWord : fineWord;
   // Byte strobes merge with the current value so single-byte writes keep the other byte
   assign strobedWord = {wStrb_q[1] ? wData_q[15:8] : oldWord[15:8],
                         wStrb_q[0] ? wData_q[7:0] : oldWord[7:0]};

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         awHeld_q <= 1'b0;
         awAddr_q <= 6'h00;
         s_axi_awready <= 1'b1;
      end else if (awTake) begin
         awHeld_q <= 1'b1;
         awAddr_q <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (wrFire) begin
         awHeld_q <= 1'b0;
      end else if (!awHeld_q && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wHeld_q <= 1'b0;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         s_axi_wready <= 1'b1;
      end else if (wTake) begin
         wHeld_q <= 1'b1;
         wData_q <= s_axi_wdata;
         wStrb_q <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (wrFire) begin
         wHeld_q <= 1'b0;
      end else if (!wHeld_q && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wrSel == 2'd3) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************************
   // Read channel
   // ****************************************************
   cdr_rd_state_t rdState_q;
   logic [1:0] rdSel;
   logic [1:0] rdSelHeld_q;
   logic [15:0] rdWord;
   logic [15:0] statusWord;
   logic arTake;
   logic extSync_q;
   logic extSync2_q;

   assign arTake = s_axi_arvalid && s_axi_arready;
   // Held select keeps read data still while the answer waits for rready
   assign rdSel = (rdState_q == RD_RESP) ? rdSelHeld_q : regSel(s_axi_araddr);

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdState_q <= RD_IDLE;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         rdSelHeld_q <= 2'd0;
      end else begin
         case (rdState_q)
            RD_IDLE: begin
               if (arTake) begin
                  rdState_q <= RD_RESP;
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid <= 1'b1;
                  rdSelHeld_q <= rdSel;
                  s_axi_rresp <= (rdSel == 2'd3 && s_axi_araddr != ADDR_STATUS) ?
                                 RESP_SLVERR : RESP_OKAY;
               end
            end
            RD_RESP: begin
               if (s_axi_rready) begin
                  rdState_q <= RD_IDLE;
                  s_axi_arready <= 1'b1;
                  s_axi_rvalid <= 1'b0;
               end
            end
            default: begin
               rdState_q <= RD_IDLE;
            end
         endcase
      end
   end

   logic rdStatus_q;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdStatus_q <= 1'b0;
      end else if (arTake) begin
         rdStatus_q <= (s_axi_araddr == ADDR_STATUS);
      end
   end

   // Status word reflects what the analog path actually receives
   // Mode pin shows after its synchroniser, two cycles behind the pin
   assign statusWord = {13'h0, analogCtrl_q.dutyStabiliserOn,
                        analogCtrl_q.delayAdjustSelect, extSync2_q};
   assign s_axi_rdata = {16'h0000, rdStatus_q ? statusWord : rdWord};

   cdr_regfile u_regfile (
      .mclk(mclk),
      .resetn(resetn),
      .wrEn(wrFire),
      .wrSel(wrSel),
      .wrData(strobedWord),
      .wrMask(selMask(wrSel)), // [R2] [R8]
      .rdSel(rdSel),
      .rdData(rdWord),
      .rangeWord(rangeWord),
      .coarseWord(coarseWord),
      .fineWord(fineWord)
   );

   // ****************************************************
   // Decode to analog controls
   // ****************************************************
   logic [11:0] coarseRaw;
   logic [11:0] coarseSat;
   logic selectOn;

   assign coarseRaw = coarseWord[COARSE_LSB +: COARSE_W]; // [R3]
   assign coarseSat = (coarseRaw > COARSE_MAX) ? COARSE_MAX : coarseRaw; // [R4]
   assign selectOn = coarseWord[SELECT_BIT];

   // Extended control mode is a pin level, synchronised before use
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         extSync_q <= 1'b0;
         extSync2_q <= 1'b0;
      end else begin
         extSync_q <= extendedControl;
         extSync2_q <= extSync_q;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         analogCtrl_q <= '{RST_RANGE[14:0], 12'h000, 6'h00, 1'b0, 1'b1};
      end else begin
         // Same code drives both modes; the analog scale maps mid-range to nominal
         analogCtrl_q.rangeCode <= rangeWord[RANGE_LSB +: RANGE_W]; // [R1] [R9] [R10]
         analogCtrl_q.coarseDelayCode <= selectOn ? coarseSat : 12'h000; // [R5]
         analogCtrl_q.fineDelayCode <= selectOn ? fineWord[FINE_LSB +: FINE_W] : 6'h00; // [R5] [R7]
         analogCtrl_q.delayAdjustSelect <= selectOn;
         analogCtrl_q.dutyStabiliserOn <= coarseWord[DUTY_BIT]; // [R6]
      end
   end

endmodule // cdr_config_regs
`default_nettype wire

// [verification/cdr_config_regs_chk.sv]
// Checker for the range and aperture delay register slice
`timescale 1ns/10ps
`default_nettype none
module cdr_config_regs_chk (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic extendedControl,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire cdr_pkg::cdr_analog_t analogCtrl_q
);
   import cdr_pkg::*;
   // ****************
   // Read address tracking
   // ****************
   logic [5:0] rdAddr_q;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) rdAddr_q <= 6'h00;
      else if (s_axi_arvalid && s_axi_arready) rdAddr_q <= s_axi_araddr;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_coarse_sat: assert property (
      analogCtrl_q.coarseDelayCode <= COARSE_MAX) else $error("coarse code above limit");
   a_select_gate: assert property (!analogCtrl_q.delayAdjustSelect |->
      analogCtrl_q.coarseDelayCode == 12'h000 && analogCtrl_q.fineDelayCode == 6'h00)
      else $error("delay applied while select off");
   a_ctrl_hold: assert property ($changed(analogCtrl_q) |-> $past(s_axi_bvalid))
      else $error("controls moved without a write");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("read response late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   a_status_bits: assert property (s_axi_rvalid && rdAddr_q == ADDR_STATUS |->
      s_axi_rdata[2:0] == {analogCtrl_q.dutyStabiliserOn, analogCtrl_q.delayAdjustSelect,
      extendedControl}) else $error("status bits wrong");
   a_range_read: assert property (s_axi_rvalid && rdAddr_q == ADDR_RANGE |->
      s_axi_rdata[15:0] == {1'b0, analogCtrl_q.rangeCode}) else $error("range mismatch");
   cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   cover property (s_axi_rvalid && rdAddr_q == ADDR_STATUS);
   cover property (analogCtrl_q.coarseDelayCode == COARSE_MAX);
endmodule // cdr_config_regs_chk
bind cdr_config_regs cdr_config_regs_chk u_chk (.mclk, .resetn, .extendedControl,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .analogCtrl_q);
`default_nettype wire

// [verification/test_clock_delay_fsr_config_regs.sv]
// Self-checking bench for the range and aperture delay register slice
`timescale 1ns/10ps
`default_nettype none
module test_clock_delay_fsr_config_regs;
   import cdr_pkg::*;
   typedef struct packed {logic [5:0] a; logic [15:0] d; logic [3:0] s; logic [15:0] e;} cdr_step_t;
   logic mclk = 1'b0, resetn = 1'b0, extendedControl = 1'b0;
   logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   cdr_analog_t analogCtrl_q;
   int err_total = 0, n_compared = 0;
   logic [15:0] shRange = 16'h4000, shCoarse = 16'h0004, shFine = 16'h0000;
   cdr_step_t steps [12] = '{'{ADDR_RANGE, 16'h7FFF, 4'hF, 16'h7FFF},
      '{ADDR_RANGE, 16'h0000, 4'h3, 16'h0000}, '{ADDR_RANGE, 16'h1234, 4'h1, 16'h0034},
      '{ADDR_COARSE, 16'h97F8, 4'hF, 16'h97F8}, '{ADDR_FINE, 16'hFC00, 4'h3, 16'hFC00},
      '{ADDR_COARSE, 16'h980C, 4'hF, 16'h980C}, '{ADDR_COARSE, 16'hFFFC, 4'h3, 16'hFFFC},
      '{ADDR_FINE, 16'h0400, 4'h3, 16'h0400}, '{ADDR_COARSE, 16'h1230, 4'h3, 16'h1230},
      '{ADDR_COARSE, 16'hAB30, 4'h2, 16'hAB30}, '{ADDR_COARSE, 16'hFF0C, 4'h1, 16'hAB0C},
      '{ADDR_RANGE, 16'h4000, 4'h3, 16'h4000}};
   always #50 mclk = ~mclk;
   cdr_config_regs dut (.mclk, .resetn, .extendedControl, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .analogCtrl_q);
   // ****************
   // Checking and bus tasks
   // ****************
   task automatic print_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic miss(input string m);
      err_total++;
      $display("MISMATCH %0t %s", $time, m);
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) miss($sformatf("data %h exp %h", got, exp));
   endtask
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      n_compared++;
      if (got !== exp) miss($sformatf("resp %b exp %b", got, exp));
   endtask
   task automatic chk_ctrl(input cdr_analog_t got, input cdr_analog_t exp);
      n_compared++;
      if (got !== exp) miss($sformatf("controls %h exp %h", got, exp));
   endtask
   function automatic cdr_analog_t expCtrl();
      cdr_analog_t e;
      e.rangeCode = shRange[14:0];
      e.delayAdjustSelect = shCoarse[3];
      e.dutyStabiliserOn = shCoarse[2];
      e.coarseDelayCode = !shCoarse[3] ? 12'h000 : (shCoarse[15:4] > 12'h97F) ? 12'h97F
         : shCoarse[15:4];
      e.fineDelayCode = shCoarse[3] ? shFine[15:10] : 6'h00;
      return e;
   endfunction
   // Ready rises with the request and drops once the answer is taken
   task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic [3:0] s,
         input logic [1:0] expResp);
      int n;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'hA5A5, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 20) begin
         miss("write wait ran out");
         print_verdict();
      end
      chk_resp(s_axi_bresp, expResp);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] expData,
         input logic [1:0] expResp);
      int n;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 20) begin
         miss("read wait ran out");
         print_verdict();
      end
      chk_word(s_axi_rdata, expData);
      chk_resp(s_axi_rresp, expResp);
   endtask
   // ****************
   // Main sequence
   // ****************
   initial begin
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      chk_ctrl(analogCtrl_q, expCtrl());
      rd(ADDR_RANGE, 32'h4000, RESP_OKAY);
      rd(ADDR_COARSE, 32'h0004, RESP_OKAY);
      rd(ADDR_FINE, 32'h0000, RESP_OKAY);
      rd(ADDR_STATUS, 32'h4, RESP_OKAY);
      foreach (steps[i]) begin
         wr(steps[i].a, steps[i].d, steps[i].s, RESP_OKAY);
         rd(steps[i].a, {16'h0, steps[i].e}, RESP_OKAY);
         if (steps[i].a == ADDR_RANGE) shRange = steps[i].e;
         if (steps[i].a == ADDR_COARSE) shCoarse = steps[i].e;
         if (steps[i].a == ADDR_FINE) shFine = steps[i].e;
         chk_ctrl(analogCtrl_q, expCtrl());
      end
      @(posedge mclk) extendedControl <= 1'b1;
      rd(ADDR_STATUS, 32'h7, RESP_OKAY);
      wr(6'h3C, 16'h1234, 4'hF, RESP_SLVERR);
      rd(6'h3C, 32'h0, RESP_SLVERR);
      chk_ctrl(analogCtrl_q, expCtrl());
      @(posedge mclk) resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      {shRange, shCoarse, shFine} = {16'h4000, 16'h0004, 16'h0000};
      chk_ctrl(analogCtrl_q, expCtrl());
      rd(ADDR_COARSE, 32'h0004, RESP_OKAY);
      print_verdict();
   end
endmodule // test_clock_delay_fsr_config_regs
`default_nettype wire
